// ---- acss_pkg_filter.sv ----
`timescale 1ns/100ps
`default_nettype none

package acss_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ASSIGN_OFS = 8'h04;
    localparam logic [7:0] MAXF_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] FREQ_OFS = 8'h10;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int RUN_SRC_LSB = 0;
    localparam int FREQ_SRC_LSB = 4;
    localparam int PAIR_LSB = 8;
    localparam int BIMODE_LSB = 12;
    localparam int FILT_LSB = 16;
    localparam int AT_ASSIGNED_BIT = 24;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int ST_KEYPAD_BIT = 0;
    localparam int ST_AT_BIT = 1;
    localparam int ST_TRIM_BIT = 2;
    localparam int ST_REV_OK_BIT = 3;
    localparam int ST_REV_DIR_BIT = 4;
    localparam int ST_ACTIVE_BIT = 5;
    localparam int ST_REJECT_BIT = 6;

    // ----------------------------------------------------------------
    // Setting codes
    // ----------------------------------------------------------------
    localparam logic [2:0] RUN_SRC_KEYPAD = 3'h2;
    localparam logic [1:0] FREQ_SRC_ANALOG = 2'h1;
    localparam logic [1:0] PAIR_CURRENT = 2'h0;
    localparam logic [1:0] PAIR_BIPOLAR = 2'h1;
    localparam logic [1:0] BIMODE_NONE = 2'h0;
    localparam logic [1:0] BIMODE_TRIM = 2'h1;
    localparam logic [1:0] BIMODE_TRIM_REV = 2'h2;
    localparam logic [5:0] OPT_KEYPAD_MON = 6'h1b;
    localparam int OPT_W = 6;
    localparam int TERM_N = 5;

    // ----------------------------------------------------------------
    // Reset values and filter limits
    // ----------------------------------------------------------------
    localparam logic [2:0] RUN_SRC_RST = 3'h1;
    localparam logic [1:0] FREQ_SRC_RST = 2'h1;
    localparam logic [1:0] PAIR_RST = 2'h0;
    localparam logic [1:0] BIMODE_RST = 2'h0;
    localparam logic [4:0] FILT_RST = 5'h08;
    localparam logic [4:0] FILT_MIN = 5'h01;
    localparam logic [4:0] FILT_MAX = 5'h1e;
    localparam logic [15:0] MAXF_RST = 16'h0fff;
    localparam int FILT_SHIFT = 2;

endpackage : acss_pkg

// One shared low-pass filter: the setting stretches the update period,
// so a larger value gives a longer time constant on every channel alike.
module acss_filter #(
    parameter int CH = 3,
    parameter int W = 13
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Setting
    input wire logic [4:0] filt_setting,
    // Samples, signed
    input wire logic [CH-1:0][W-1:0] x_in,
    output logic [CH-1:0][W-1:0] y_out
);

    typedef struct packed {
        logic [4:0] cnt;
        logic [CH-1:0][W-1:0] y;
    } acss_filt_s;

    acss_filt_s st_q;
    acss_filt_s st_d;
    logic [4:0] limit;
    logic [CH-1:0][W-1:0] y_next;

    // Out-of-range settings are pulled into the legal span
    assign limit = (filt_setting < acss_pkg::FILT_MIN) ? acss_pkg::FILT_MIN :
                   (filt_setting > acss_pkg::FILT_MAX) ? acss_pkg::FILT_MAX :
                   filt_setting;

    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : g_ch
            logic signed [W:0] diff;
            assign diff = $signed({x_in[g][W-1], x_in[g]})
                        - $signed({st_q.y[g][W-1], st_q.y[g]});
            assign y_next[g] = st_q.y[g]
                             + W'(diff >>> acss_pkg::FILT_SHIFT);
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        if (st_q.cnt >= limit - 5'h01)
        begin
            st_d.cnt = 5'h00;
            st_d.y = y_next;
        end
        else
        begin
            st_d.cnt = st_q.cnt + 5'h01;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign y_out = st_q.y;

endmodule : acss_filter

`default_nettype wire

// ---- acss_top.sv ----
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Keypad flag on when run source is 02
// - Keypad flag off for other run sources
// - Network cannot assign or remove keypad monitor
// - Network may still read terminal assignments
// - Select off: primary voltage input commands
// - Select on, pair 00: current input commands
// - One filter setting 1..30 for all inputs
// - Select on, pair 01: bipolar sole, reversible
// - Bipolar trim only modes 01/02, not primary; code 03 also trims here
// - Reverse if mode 02 or bipolar primary
// - Positive bipolar forward, negative reverse
// - Select unassigned: pair setting ignored
// - Unassigned: mode selects bipolar or summation
// - Select input re-evaluated during operation
module acss_top #(
    parameter int ADC_W = 12,
    parameter int FREQ_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Marks the current bus access as coming from the network host
    input wire logic net_access,
    // Pins and converted analog samples
    input wire logic analog_type_select,
    input wire logic [ADC_W-1:0] voltage_input,
    input wire logic [ADC_W-1:0] current_loop_input,
    input wire logic signed [ADC_W:0] bipolar_voltage_input,
    // Command and terminal outputs
    output logic [FREQ_W-1:0] freq_cmd,
    output logic dir_reverse,
    output logic cmd_active,
    output logic keypad_source_flag,
    output logic [acss_pkg::TERM_N-1:0] out_terminal
);

    localparam int SW = FREQ_W + 2;
    localparam int AW = acss_pkg::TERM_N * acss_pkg::OPT_W;

    typedef struct packed {
        logic at_meta;
        logic at_sync;
        logic [2:0] run_source_setting;
        logic [1:0] freq_source_setting;
        logic [1:0] select_pair_setting;
        logic [1:0] bipolar_mode_setting;
        logic [4:0] input_filter_setting;
        logic at_assigned;
        logic [AW-1:0] assign_map;
        logic [FREQ_W-1:0] max_freq;
        logic reject_flag;
        logic keypad;
        logic [acss_pkg::TERM_N-1:0] term;
        logic [FREQ_W-1:0] freq;
        logic rev;
        logic rev_ok;
        logic trim_on;
        logic active;
        logic ack;
        logic [31:0] rdata;
    } acss_state_s;

    acss_state_s st_q;
    acss_state_s st_d;

    // ----------------------------------------------------------------
    // Input filter
    // ----------------------------------------------------------------
    logic [2:0][ADC_W:0] filt_in;
    logic [2:0][ADC_W:0] filt_out;

    assign filt_in[0] = {1'b0, voltage_input};
    assign filt_in[1] = {1'b0, current_loop_input};
    assign filt_in[2] = bipolar_voltage_input;

    acss_filter #(
        .CH(3),
        .W(ADC_W + 1)
    ) u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .filt_setting(st_q.input_filter_setting),
        .x_in(filt_in),
        .y_out(filt_out)
    );

    // ----------------------------------------------------------------
    // Terminal assignment write filter
    // ----------------------------------------------------------------
    logic bus_req;
    logic wr_hit;
    logic [31:0] wmask;
    logic [AW-1:0] assign_wr;
    logic [AW-1:0] assign_new;
    logic [acss_pkg::TERM_N-1:0] blocked;

    assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
    assign wr_hit = bus_req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign assign_wr = AW'((wb_dat_i & wmask)
                     | ({{(32 - AW){1'b0}}, st_q.assign_map} & ~wmask));

    genvar t;
    generate
        for (t = 0; t < acss_pkg::TERM_N; t++)
        begin : g_term
            logic [acss_pkg::OPT_W-1:0] old_c;
            logic [acss_pkg::OPT_W-1:0] new_c;
            assign old_c = st_q.assign_map[t*acss_pkg::OPT_W +:
                                           acss_pkg::OPT_W];
            assign new_c = assign_wr[t*acss_pkg::OPT_W +: acss_pkg::OPT_W];
            // Network may not move a terminal onto or off the monitor
            assign blocked[t] = net_access && (old_c != new_c)
                && (old_c == acss_pkg::OPT_KEYPAD_MON
                    || new_c == acss_pkg::OPT_KEYPAD_MON);
            assign assign_new[t*acss_pkg::OPT_W +: acss_pkg::OPT_W] =
                blocked[t] ? old_c : new_c;
            assign out_terminal[t] = st_q.term[t];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Frequency command path
    // ----------------------------------------------------------------
    logic signed [SW-1:0] v_s;
    logic signed [SW-1:0] i_s;
    logic signed [SW-1:0] b_s;
    logic signed [SW-1:0] prim;
    logic signed [SW-1:0] trim;
    logic signed [SW-1:0] tot;
    logic signed [SW-1:0] mag;
    logic o2_primary;
    logic trim_on;
    logic rev_ok;
    logic neg;
    logic [FREQ_W-1:0] freq_new;

    assign v_s = $signed({{(SW - ADC_W - 1){1'b0}}, filt_out[0]});
    assign i_s = $signed({{(SW - ADC_W - 1){1'b0}}, filt_out[1]});
    assign b_s = $signed({{(SW - ADC_W - 1){filt_out[2][ADC_W]}},
                          filt_out[2]});

    always_comb
    begin
        o2_primary = 1'b0;
        prim = v_s;
        if (st_q.at_assigned)
        begin
            // Synchronised select state is taken every cycle, two edges behind the pin
            if (st_q.at_sync)
            begin
                if (st_q.select_pair_setting == acss_pkg::PAIR_BIPOLAR)
                begin
                    o2_primary = 1'b1;
                    prim = b_s;
                end
                else
                begin
                    prim = i_s;
                end
            end
        end
        else if (st_q.bipolar_mode_setting == acss_pkg::BIMODE_NONE)
        begin
            o2_primary = 1'b1;
            prim = b_s;
        end
        else
        begin
            prim = v_s + i_s;
        end
    end

    // Codes beyond 02 act as no-reverse trim, the safer reading
    assign trim_on = !o2_primary
        && (st_q.bipolar_mode_setting != acss_pkg::BIMODE_NONE);
    assign rev_ok = o2_primary
        || (st_q.bipolar_mode_setting == acss_pkg::BIMODE_TRIM_REV);
    // Without reverse the bipolar trim is held unipolar
    assign trim = !trim_on ? '0 :
                  (!rev_ok && b_s < 0) ? '0 : b_s;
    assign tot = prim + trim;
    assign neg = rev_ok && (tot < 0);
    assign mag = (tot < 0) ? (rev_ok ? -tot : '0) : tot;
    assign freq_new = (mag > $signed({2'b00, st_q.max_freq})) ?
                      st_q.max_freq : FREQ_W'(mag);

    // ----------------------------------------------------------------
    // State update
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.at_meta = analog_type_select;
        st_d.at_sync = st_q.at_meta;
        st_d.keypad = (st_q.run_source_setting
                       == acss_pkg::RUN_SRC_KEYPAD);
        for (int k = 0; k < acss_pkg::TERM_N; k++)
        begin
            st_d.term[k] = st_q.keypad
                && (st_q.assign_map[k*acss_pkg::OPT_W +: acss_pkg::OPT_W]
                    == acss_pkg::OPT_KEYPAD_MON);
        end
        st_d.active = (st_q.freq_source_setting
                       == acss_pkg::FREQ_SRC_ANALOG);
        st_d.freq = st_q.active ? freq_new : '0;
        st_d.rev = st_q.active && neg;
        st_d.rev_ok = rev_ok;
        st_d.trim_on = trim_on;
        st_d.ack = bus_req;
        st_d.rdata = '0;
        if (wr_hit)
        begin
            unique case (wb_adr_i)
                acss_pkg::CTRL_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        st_d.run_source_setting =
                            wb_dat_i[acss_pkg::RUN_SRC_LSB +: 3];
                        st_d.freq_source_setting =
                            wb_dat_i[acss_pkg::FREQ_SRC_LSB +: 2];
                    end
                    if (wb_sel_i[1])
                    begin
                        st_d.select_pair_setting =
                            wb_dat_i[acss_pkg::PAIR_LSB +: 2];
                        st_d.bipolar_mode_setting =
                            wb_dat_i[acss_pkg::BIMODE_LSB +: 2];
                    end
                    if (wb_sel_i[2])
                        st_d.input_filter_setting =
                            wb_dat_i[acss_pkg::FILT_LSB +: 5];
                    if (wb_sel_i[3])
                        st_d.at_assigned =
                            wb_dat_i[acss_pkg::AT_ASSIGNED_BIT];
                end
                acss_pkg::ASSIGN_OFS:
                    st_d.assign_map = assign_new;
                acss_pkg::MAXF_OFS:
                    st_d.max_freq = FREQ_W'((wb_dat_i & wmask)
                        | ({{(32 - FREQ_W){1'b0}}, st_q.max_freq}
                           & ~wmask));
                acss_pkg::STATUS_OFS:
                    if (wb_sel_i[0] && wb_dat_i[acss_pkg::ST_REJECT_BIT])
                        st_d.reject_flag = 1'b0;
                default:
                    st_d.rdata = '0;
            endcase
        end
        // A fresh refusal wins over a clear in the same cycle
        if (wr_hit && wb_adr_i == acss_pkg::ASSIGN_OFS && |blocked)
            st_d.reject_flag = 1'b1;
        if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                acss_pkg::CTRL_OFS:
                begin
                    st_d.rdata[acss_pkg::RUN_SRC_LSB +: 3] =
                        st_q.run_source_setting;
                    st_d.rdata[acss_pkg::FREQ_SRC_LSB +: 2] =
                        st_q.freq_source_setting;
                    st_d.rdata[acss_pkg::PAIR_LSB +: 2] =
                        st_q.select_pair_setting;
                    st_d.rdata[acss_pkg::BIMODE_LSB +: 2] =
                        st_q.bipolar_mode_setting;
                    st_d.rdata[acss_pkg::FILT_LSB +: 5] =
                        st_q.input_filter_setting;
                    st_d.rdata[acss_pkg::AT_ASSIGNED_BIT] = st_q.at_assigned;
                end
                acss_pkg::ASSIGN_OFS:
                    st_d.rdata[AW-1:0] = st_q.assign_map;
                acss_pkg::MAXF_OFS:
                    st_d.rdata[FREQ_W-1:0] = st_q.max_freq;
                acss_pkg::STATUS_OFS:
                begin
                    st_d.rdata[acss_pkg::ST_KEYPAD_BIT] = st_q.keypad;
                    st_d.rdata[acss_pkg::ST_AT_BIT] = st_q.at_sync;
                    st_d.rdata[acss_pkg::ST_TRIM_BIT] = st_q.trim_on;
                    st_d.rdata[acss_pkg::ST_REV_OK_BIT] = st_q.rev_ok;
                    st_d.rdata[acss_pkg::ST_REV_DIR_BIT] = st_q.rev;
                    st_d.rdata[acss_pkg::ST_ACTIVE_BIT] = st_q.active;
                    st_d.rdata[acss_pkg::ST_REJECT_BIT] = st_q.reject_flag;
                end
                acss_pkg::FREQ_OFS:
                    st_d.rdata[FREQ_W-1:0] = st_q.freq;
                default:
                    st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.run_source_setting <= acss_pkg::RUN_SRC_RST;
            st_q.freq_source_setting <= acss_pkg::FREQ_SRC_RST;
            st_q.select_pair_setting <= acss_pkg::PAIR_RST;
            st_q.bipolar_mode_setting <= acss_pkg::BIMODE_RST;
            st_q.input_filter_setting <= acss_pkg::FILT_RST;
            st_q.at_assigned <= 1'b1;
            st_q.max_freq <= FREQ_W'(acss_pkg::MAXF_RST);
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdata;
    assign freq_cmd = st_q.freq;
    assign dir_reverse = st_q.rev;
    assign cmd_active = st_q.active;
    assign keypad_source_flag = st_q.keypad;

endmodule : acss_top

`default_nettype wire

// ---- acss_top_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module acss_top_props #(
    parameter int ADC_W = 12,
    parameter int FREQ_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Outputs
    input wire logic [FREQ_W-1:0] freq_cmd,
    input wire logic dir_reverse,
    input wire logic cmd_active,
    input wire logic keypad_source_flag,
    input wire logic [acss_pkg::TERM_N-1:0] out_terminal
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic req;
    logic ctrl_wr;
    logic rd_unmapped;
    assign req = wb_cyc_i && wb_stb_i;
    assign ctrl_wr = req && wb_we_i && wb_adr_i == acss_pkg::CTRL_OFS;
    assign rd_unmapped = req && !wb_we_i &&
        !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_unmapped_zero: assert property (
        wb_ack_o && $past(rd_unmapped) |-> wb_dat_o == 32'h0)
        else $error("unmapped read returned data");
    a_flag_cause: assert property (
        $changed(keypad_source_flag) |-> $past(ctrl_wr, 2))
        else $error("keypad flag moved without a control write");
    a_term_flag: assert property (
        |out_terminal |-> $past(keypad_source_flag))
        else $error("terminal on while keypad flag off");
    a_idle_cmd: assert property (
        !cmd_active [*2] |-> freq_cmd == '0 && !dir_reverse)
        else $error("command present while inactive");
    a_active_cause: assert property ($changed(cmd_active) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2) || !$past(rst_n, 3))
        else $error("active moved without a control write");

    c_flag: cover property ($rose(keypad_source_flag));
    c_reverse: cover property ($rose(dir_reverse));
    c_terminal: cover property (|out_terminal);
endmodule : acss_top_props

bind acss_top acss_top_props #(.ADC_W(ADC_W), .FREQ_W(FREQ_W))
    acss_top_props_i (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .freq_cmd(freq_cmd),
    .dir_reverse(dir_reverse), .cmd_active(cmd_active),
    .keypad_source_flag(keypad_source_flag), .out_terminal(out_terminal));

`default_nettype wire

// ---- acss_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Analog sources: converter samples follow the requested levels one edge
// later, as a real converter would present them.
module acss_src_model (
    // Clock
    input wire logic core_clk,
    // Requested levels
    input wire logic [11:0] set_v,
    input wire logic [11:0] set_i,
    input wire logic signed [12:0] set_b,
    input wire logic set_sel,
    // Toward the block
    output logic [11:0] voltage_input = 12'h000,
    output logic [11:0] current_loop_input = 12'h000,
    output logic signed [12:0] bipolar_voltage_input = 13'h0000,
    output logic analog_type_select = 1'b0
);
    always @(posedge core_clk)
    begin
        voltage_input <= set_v;
        current_loop_input <= set_i;
        bipolar_voltage_input <= set_b;
        analog_type_select <= set_sel;
    end
endmodule : acss_src_model

`default_nettype wire

// ---- test_analog_command_source_select.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_analog_command_source_select;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic net = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack;
    logic [15:0] freq;
    logic dir;
    logic act;
    logic kflag;
    logic [4:0] term;
    logic [11:0] sv = 12'h000;
    logic [11:0] si = 12'h000;
    logic signed [12:0] sb = 13'h0000;
    logic ssel = 1'b0;
    logic [11:0] pv;
    logic [11:0] pi;
    logic signed [12:0] pb;
    logic psel;

    acss_src_model acss_src_model_i (.core_clk(core_clk), .set_v(sv),
        .set_i(si), .set_b(sb), .set_sel(ssel), .voltage_input(pv),
        .current_loop_input(pi), .bipolar_voltage_input(pb),
        .analog_type_select(psel));

    acss_top acss_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .net_access(net), .analog_type_select(psel), .voltage_input(pv),
        .current_loop_input(pi), .bipolar_voltage_input(pb),
        .freq_cmd(freq), .dir_reverse(dir), .cmd_active(act),
        .keypad_source_flag(kflag), .out_terminal(term));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic n);
        @(posedge core_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        net <= n;
        @(posedge core_clk);
        while (ack !== 1'b1)
            @(posedge core_clk);
        rd = rdat;
        cyc <= 1'b0;
        net <= 1'b0;
    endtask : bus

    function automatic logic [31:0] ctrl(input logic [2:0] run,
        input logic [1:0] fs, pair, mode, input logic [4:0] filt,
        input logic asg);
        return {7'h0, asg, 3'h0, filt, 2'h0, mode, 2'h0, pair, 2'h0, fs,
                1'h0, run};
    endfunction : ctrl

    // Approach each level from above: the filter then lands on it exactly
    task automatic row(input logic asg, sel, input logic [1:0] pair, mode,
        input logic [12:0] b, input logic [15:0] f, input logic d);
        bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'h1, 2'h1, pair, mode, 5'h01,
            asg), 1'b0);
        sv <= 12'hfff;
        si <= 12'hfff;
        sb <= 13'h0fff;
        repeat (80) @(posedge core_clk);
        sv <= 12'h123;
        si <= 12'h456;
        sb <= b;
        ssel <= sel;
        repeat (80) @(posedge core_clk);
        check("freq", {16'h0, freq}, {16'h0, f});
        check("dir", {31'h0, dir}, {31'h0, d});
    endtask : row

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        bus(1'b0, acss_pkg::CTRL_OFS, 32'h0, 1'b0);
        check("ctrl", rd, 32'h01080011);
        bus(1'b0, acss_pkg::MAXF_OFS, 32'h0, 1'b0);
        check("maxf", rd, 32'h00000fff);
        bus(1'b0, acss_pkg::ASSIGN_OFS, 32'h0, 1'b0);
        check("assign", rd, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff, 1'b0);
        bus(1'b0, 8'h40, 32'h0, 1'b0);
        check("unmapped", rd, 32'h0);
        check("keypad", {31'h0, kflag}, 32'h0);
    endtask : t_reset

    task automatic t_keypad();
        for (int r = 1; r <= 5; r++)
        begin
            bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'(r), 2'h1, 2'h0, 2'h0,
                5'h01, 1'b1), 1'b0);
            repeat (2) @(posedge core_clk);
            check("keypad", {31'h0, kflag}, 32'(r == 2));
        end
    endtask : t_keypad

    task automatic t_assign();
        // Keypad must own the run source for the monitor terminal to light
        bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'h2, 2'h1, 2'h0, 2'h0, 5'h01,
            1'b1), 1'b0);
        bus(1'b1, acss_pkg::ASSIGN_OFS, 32'h0000001b, 1'b0);
        repeat (3) @(posedge core_clk);
        check("term", {27'h0, term}, 32'h1);
        bus(1'b1, acss_pkg::ASSIGN_OFS, 32'h000056c0, 1'b1);
        bus(1'b0, acss_pkg::ASSIGN_OFS, 32'h0, 1'b1);
        check("assign", rd, 32'h0000501b);
        bus(1'b0, acss_pkg::STATUS_OFS, 32'h0, 1'b0);
        check("reject", {31'h0, rd[6]}, 32'h1);
        bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'h3, 2'h1, 2'h0, 2'h0, 5'h01,
            1'b1), 1'b0);
        repeat (3) @(posedge core_clk);
        check("term", {27'h0, term}, 32'h0);
    endtask : t_assign

    task automatic t_source();
        bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'h1, 2'h0, 2'h0, 2'h0, 5'h01,
            1'b1), 1'b0);
        repeat (3) @(posedge core_clk);
        check("idle", {15'h0, act, freq}, 32'h0);
    endtask : t_source

    task automatic t_filter();
        row(1, 0, 0, 0, 13'h0100, 16'h0123, 0);
        bus(1'b1, acss_pkg::CTRL_OFS, ctrl(3'h1, 2'h1, 2'h0, 2'h0, 5'h1e,
            1'b1), 1'b0);
        sv <= 12'h000;
        repeat (100) @(posedge core_clk);
        check("slow", {31'h0, freq == 16'h0}, 32'h0);
        repeat (3000) @(posedge core_clk);
        check("slow", {16'h0, freq}, 32'h0);
    endtask : t_filter

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_keypad();
        t_assign();
        row(1, 0, 0, 0, 13'h0100, 16'h0123, 0);
        row(1, 1, 0, 0, 13'h0100, 16'h0456, 0);
        row(1, 1, 1, 0, 13'h1f00, 16'h0100, 1);
        row(1, 1, 1, 1, 13'h0200, 16'h0200, 0);
        row(1, 1, 0, 2, 13'h0100, 16'h0556, 0);
        row(1, 0, 1, 1, 13'h1f00, 16'h0123, 0);
        row(0, 1, 1, 0, 13'h1f80, 16'h0080, 1);
        row(0, 0, 1, 1, 13'h0100, 16'h0679, 0);
        row(0, 0, 0, 1, 13'h1f00, 16'h0579, 0);
        row(0, 1, 0, 2, 13'h0100, 16'h0679, 0);
        bus(1'b1, acss_pkg::MAXF_OFS, 32'h00000300, 1'b0);
        row(0, 0, 0, 1, 13'h0100, 16'h0300, 0);
        bus(1'b1, acss_pkg::MAXF_OFS, 32'h00000fff, 1'b0);
        row(1, 0, 0, 1, 13'h0100, 16'h0223, 0);
        ssel <= 1'b1;
        repeat (20) @(posedge core_clk);
        check("toggle", {16'h0, freq}, 32'h0556);
        t_source();
        t_filter();
        conclude();
    end

    // Cut a hang short well beyond the expected run length
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end
endmodule : test_analog_command_source_select

`default_nettype wire
